// file: rtl/adc_sequencing_control.sv
module adc_sequencing_control (
    // Clock, reset, enable
    input  logic                  hclk,
    input  logic                  hresetn,
    input  logic                  ce,
    // AHB-Lite slave
    input  logic                  hsel,
    input  logic [31:0]           haddr,
    input  logic [1:0]            htrans,
    input  logic                  hwrite,
    input  logic [2:0]            hsize,
    input  logic [31:0]           hwdata,
    input  logic                  hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // System power state, same clock
    input  adc_ctrl_pkg::pwr_mode_t power_mode,
    // Pins and analog core
    input  logic                  external_trigger_pin,
    input  logic                  comp_in,
    output logic [7:0]            ch_sel,
    output logic [9:0]            dac_code,
    output logic                  sample_en,
    output logic                  converter_enable,
    // Interrupt request
    output logic                  conv_done_irq
);
    import adc_ctrl_pkg::*;

    typedef struct packed {
        logic        fast;
        logic        trig_en;
        logic [3:0]  chan;
        logic        start_flag;
        logic [5:0]  stop1;
        logic        done_req;
        logic        done_ien;
        logic        int4_pin_fn;
        logic        int4_rising;
        logic        start_p;
        logic        abort_p;
        logic        run;
        logic [7:0]  ch_sel;
        logic        irq;
        logic        dp_valid;
        logic        dp_write;
        logic [15:0] dp_idx;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } ctrl_reg_t;

    ctrl_reg_t  s_r;
    ctrl_reg_t  s_nxt;
    logic [9:0] result_r;
    logic       trig_pulse;

    conv_if cv ();

    function automatic logic [31:0] read_word(
        input logic [15:0] idx,
        input ctrl_reg_t   s,
        input logic [9:0]  res
    );
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            // Intermediate reads permitted; value only valid when idle
            IDX_RESULT_HIGH: b = res[9:2];
            IDX_RESULT_LOW:  b = {res[1:0], 6'h00};
            IDX_MODE:        b = {s.fast, s.trig_en, 2'b00, s.chan}
                                 | MODE_ONES;
            IDX_START:       b = {s.start_flag, 7'h00}
                                 | START_ONES;
            IDX_CLK_STOP1:   b = {2'b00, s.stop1} | STOP1_ONES;
            IDX_IRQ_REQ2:    b = 8'(s.done_req) << IRQ_DONE_BIT;
            IDX_IRQ_EN2:     b = 8'(s.done_ien) << IRQ_DONE_BIT;
            IDX_PORT_MODE1:  b = 8'(s.int4_pin_fn) << PIN_INT4_BIT;
            IDX_EDGE_SEL:    b = 8'(s.int4_rising) << EDGE_INT4_BIT;
            default:         b = 8'h00;
        endcase
        return {24'h000000, b};
    endfunction : read_word

    function automatic logic [7:0] decode_chan(input logic [3:0] c);
        logic [7:0] oh;
        oh = 8'h00;
        case (c[3:2])
            2'b01:   oh = 8'h01 << c[1:0];
            2'b10:   oh = 8'h10 << c[1:0];
            // No channel, and the prohibited setting, drive nothing
            default: oh = 8'h00;
        endcase
        return oh;
    endfunction : decode_chan

    always_comb
    begin
        logic       operating;
        logic       wr;
        logic [7:0] wd;
        logic       sw_start_wr;
        operating = s_r.stop1[STOP1_CONV_BIT] &&
                    (power_mode == PWR_ACTIVE ||
                     power_mode == PWR_SLEEP);
        wr          = 1'b0;
        wd          = hwdata[7:0];
        sw_start_wr = 1'b0;
        s_nxt         = s_r;
        s_nxt.start_p = 1'b0;
        s_nxt.abort_p = 1'b0;
        s_nxt.hresp   = 1'b0;
        s_nxt.run     = operating;

        if (s_r.hreadyout)
        begin
            wr = s_r.dp_valid && s_r.dp_write;
            if (hsel && htrans[1] && hready)
            begin
                s_nxt.dp_valid  = 1'b1;
                s_nxt.dp_write  = hwrite;
                s_nxt.dp_idx    = haddr[17:2];
                // Read data come from a flop, so reads take a wait state
                s_nxt.hreadyout = hwrite;
            end
            else
                s_nxt.dp_valid = 1'b0;
        end
        else
        begin
            s_nxt.hrdata    = read_word(s_r.dp_idx, s_r, result_r);
            s_nxt.hreadyout = 1'b1;
            s_nxt.dp_valid  = 1'b0;
        end

        if (wr)
        begin
            case (s_r.dp_idx)
                IDX_MODE:
                    // Frozen registers keep their values out of operation
                    if (operating)
                    begin
                        s_nxt.fast    = wd[MODE_FAST_BIT];
                        s_nxt.trig_en = wd[MODE_TRIG_BIT];
                        s_nxt.chan    = wd[3:0];
                    end
                IDX_START:
                    if (operating)
                    begin
                        sw_start_wr = 1'b1;
                        if (!wd[START_FLAG_BIT])
                        begin
                            s_nxt.start_flag = 1'b0;
                            s_nxt.abort_p    = 1'b1;
                        end
                        else if (!s_r.start_flag)
                        begin
                            s_nxt.start_flag = 1'b1;
                            s_nxt.start_p    = 1'b1;
                        end
                    end
                IDX_CLK_STOP1:
                    s_nxt.stop1 = wd[5:0];
                IDX_IRQ_REQ2:
                    if (!wd[IRQ_DONE_BIT])
                        s_nxt.done_req = 1'b0;
                IDX_IRQ_EN2:
                    s_nxt.done_ien = wd[IRQ_DONE_BIT];
                IDX_PORT_MODE1:
                    s_nxt.int4_pin_fn = wd[PIN_INT4_BIT];
                IDX_EDGE_SEL:
                    s_nxt.int4_rising = wd[EDGE_INT4_BIT];
                // Must not cancel an address phase taken this cycle
                default: ;
            endcase
        end

        // Trigger starts only an idle converter
        if (trig_pulse && operating && !s_r.start_flag &&
            !sw_start_wr)
        begin
            s_nxt.start_flag = 1'b1;
            s_nxt.start_p    = 1'b1;
        end

        // Completion wins over a same-cycle request clear
        if (cv.done && s_r.start_flag && !s_nxt.abort_p)
        begin
            s_nxt.start_flag = 1'b0;
            s_nxt.done_req   = 1'b1;
        end

        s_nxt.ch_sel = decode_chan(s_r.chan);
        s_nxt.irq    = s_r.done_req && s_r.done_ien;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_r             <= '0;
            s_r.fast        <= MODE_RST[MODE_FAST_BIT];
            s_r.trig_en     <= MODE_RST[MODE_TRIG_BIT];
            s_r.chan        <= MODE_RST[3:0];
            s_r.start_flag  <= START_RST[START_FLAG_BIT];
            s_r.stop1       <= STOP1_RST[5:0];
            s_r.hreadyout   <= 1'b1;
        end
        else if (ce)
            s_r <= s_nxt;
    end

    // Result survives reset, so it has no reset term
    always_ff @(posedge hclk)
    begin
        if (ce && cv.done && s_r.start_flag && !s_nxt.abort_p)
            result_r <= cv.result;
    end

    assign cv.start = s_r.start_p;
    assign cv.abort = s_r.abort_p;
    assign cv.run   = s_r.run;
    assign cv.slow  = s_r.fast;

    trig_detect u_trig (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .pin     (external_trigger_pin),
        .enable  (s_r.int4_pin_fn && s_r.trig_en),
        .rising  (s_r.int4_rising),
        .pulse   (trig_pulse)
    );

    sar_engine u_sar (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .comp_in   (comp_in),
        .dac_code  (dac_code),
        .sample_en (sample_en),
        .cv        (cv)
    );

    assign hrdata           = s_r.hrdata;
    assign hreadyout        = s_r.hreadyout;
    assign hresp            = s_r.hresp;
    assign ch_sel           = s_r.ch_sel;
    assign converter_enable = s_r.stop1[STOP1_CONV_BIT];
    assign conv_done_irq    = s_r.irq;
endmodule : adc_sequencing_control

// file: rtl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_RESULT_HIGH = 16'hffc4;
    localparam logic [15:0] IDX_RESULT_LOW  = 16'hffc5;
    localparam logic [15:0] IDX_MODE        = 16'hffc6;
    localparam logic [15:0] IDX_START       = 16'hffc7;
    localparam logic [15:0] IDX_CLK_STOP1   = 16'hfffa;
    localparam logic [15:0] IDX_IRQ_REQ2    = 16'hffe0;
    localparam logic [15:0] IDX_IRQ_EN2     = 16'hffe1;
    localparam logic [15:0] IDX_PORT_MODE1  = 16'hffe2;
    localparam logic [15:0] IDX_EDGE_SEL    = 16'hffe3;

    localparam int MODE_FAST_BIT  = 7;
    localparam int MODE_TRIG_BIT  = 6;
    localparam int START_FLAG_BIT = 7;
    localparam int STOP1_CONV_BIT = 4;
    localparam int IRQ_DONE_BIT   = 3;
    localparam int PIN_INT4_BIT   = 4;
    localparam int EDGE_INT4_BIT  = 4;

    localparam logic [7:0] MODE_RST      = 8'h30;
    localparam logic [7:0] START_RST     = 8'h7f;
    localparam logic [7:0] STOP1_RST     = 8'hff;
    localparam logic [7:0] MODE_ONES     = 8'h30;
    localparam logic [7:0] START_ONES    = 8'h7f;
    localparam logic [7:0] STOP1_ONES    = 8'hc0;

    localparam int RESULT_W = 10;

    // Conversion period split: sample phase plus ten bit steps
    localparam int          PERIOD_SLOW_CLKS = 62;
    localparam int          PERIOD_FAST_CLKS = 31;
    localparam logic [5:0]  STEP_SLOW   = 6'h04;
    // Fast steps take three clocks: the comparator sync needs two
    localparam logic [5:0]  STEP_FAST   = 6'h03;
    localparam logic [5:0]  SAMPLE_SLOW =
        6'(PERIOD_SLOW_CLKS - RESULT_W * 4);
    localparam logic [5:0]  SAMPLE_FAST =
        6'(PERIOD_FAST_CLKS - RESULT_W * 3);

    typedef enum logic [2:0] {
        PWR_ACTIVE    = 3'b000,
        PWR_SLEEP     = 3'b001,
        PWR_WATCH     = 3'b010,
        PWR_SUBACTIVE = 3'b011,
        PWR_SUBSLEEP  = 3'b100,
        PWR_STANDBY   = 3'b101
    } pwr_mode_t;

    typedef enum logic [1:0] {
        SAR_IDLE    = 2'b00,
        SAR_SAMPLE  = 2'b01,
        SAR_CONVERT = 2'b10
    } sar_state_t;

endpackage : adc_ctrl_pkg

// file: rtl/conv_if.sv
interface conv_if;
    logic       start;
    logic       abort;
    logic       run;
    logic       slow;
    logic       busy;
    logic       done;
    logic [9:0] result;

    modport ctrl (output start, abort, run, slow,
                  input  busy, done, result);
    modport sar  (input  start, abort, run, slow,
                  output busy, done, result);
endinterface : conv_if

// file: rtl/trig_detect.sv
module trig_detect (
    // Clock and reset
    input  logic hclk,
    input  logic hresetn,
    input  logic ce,
    // Trigger pin and selection
    input  logic pin,
    input  logic enable,
    input  logic rising,
    // Detected edge
    output logic pulse
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic pulse;
    } trig_state_t;

    trig_state_t s_r;
    trig_state_t s_nxt;

    always_comb
    begin
        s_nxt    = s_r;
        s_nxt.s1 = pin;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        // Edge looks only at the second and third stages
        s_nxt.pulse = enable &&
            (rising ? (s_r.s2 && !s_r.s3)
                    : (!s_r.s2 && s_r.s3));
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_r <= '0;
        else if (ce)
            s_r <= s_nxt;
    end

    assign pulse = s_r.pulse;
endmodule : trig_detect

// file: rtl/sar_engine.sv
module sar_engine (
    // Clock and reset
    input  logic   hclk,
    input  logic   hresetn,
    input  logic   ce,
    // Analog core
    input  logic   comp_in,
    output logic [9:0] dac_code,
    output logic   sample_en,
    // Control side
    conv_if.sar    cv
);
    import adc_ctrl_pkg::*;

    typedef struct packed {
        sar_state_t state;
        logic [5:0] cnt;
        logic [3:0] bitpos;
        logic [9:0] work;
        logic       comp_s1;
        logic       comp_s2;
        logic       sample;
        logic       done;
        logic [9:0] result;
    } sar_reg_t;

    sar_reg_t s_r;
    sar_reg_t s_nxt;

    always_comb
    begin
        logic [9:0] tmp;
        logic [5:0] step;
        tmp  = '0;
        step = cv.slow ? STEP_FAST : STEP_SLOW;
        s_nxt         = s_r;
        s_nxt.done    = 1'b0;
        s_nxt.comp_s1 = comp_in;
        s_nxt.comp_s2 = s_r.comp_s1;
        if (cv.abort)
        begin
            s_nxt.state  = SAR_IDLE;
            s_nxt.sample = 1'b0;
        end
        else if (cv.run)
        begin
            case (s_r.state)
                SAR_IDLE:
                    if (cv.start)
                    begin
                        s_nxt.state  = SAR_SAMPLE;
                        s_nxt.sample = 1'b1;
                        s_nxt.work   = '0;
                        s_nxt.cnt    = (cv.slow ? SAMPLE_FAST
                                                : SAMPLE_SLOW) - 6'h01;
                    end
                SAR_SAMPLE:
                    if (s_r.cnt == 6'h00)
                    begin
                        s_nxt.state  = SAR_CONVERT;
                        s_nxt.sample = 1'b0;
                        s_nxt.bitpos = 4'h9;
                        s_nxt.work   = 10'h200;
                        s_nxt.cnt    = step - 6'h01;
                    end
                    else
                        s_nxt.cnt = s_r.cnt - 6'h01;
                SAR_CONVERT:
                    if (s_r.cnt == 6'h00)
                    begin
                        // Comparator high: input above trial, keep bit
                        tmp = s_r.comp_s2 ? s_r.work
                            : s_r.work & ~(10'h001 << s_r.bitpos);
                        if (s_r.bitpos == 4'h0)
                        begin
                            s_nxt.state  = SAR_IDLE;
                            s_nxt.work   = tmp;
                            s_nxt.result = tmp;
                            s_nxt.done   = 1'b1;
                        end
                        else
                        begin
                            s_nxt.bitpos = s_r.bitpos - 4'h1;
                            s_nxt.work   = tmp |
                                (10'h001 << (s_r.bitpos - 4'h1));
                            s_nxt.cnt    = step - 6'h01;
                        end
                    end
                    else
                        s_nxt.cnt = s_r.cnt - 6'h01;
                default:
                    s_nxt.state = SAR_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_r <= '0;
        else if (ce)
            s_r <= s_nxt;
    end

    assign cv.busy   = (s_r.state != SAR_IDLE);
    assign cv.done   = s_r.done;
    assign cv.result = s_r.result;
    assign dac_code  = s_r.work;
    assign sample_en = s_r.sample;
endmodule : sar_engine

// file: dv/adc_seq_monitor.sv
module adc_seq_monitor
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic                    hclk,
    input wire logic                    hresetn,
    // Register bus
    input wire logic                    hsel,
    input wire logic [31:0]             haddr,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic [31:0]             hwdata,
    input wire logic                    hready,
    input wire logic [31:0]             hrdata,
    input wire logic                    hreadyout,
    // Converter side
    input wire adc_ctrl_pkg::pwr_mode_t power_mode,
    input wire logic [7:0]              ch_sel,
    input wire logic [9:0]              dac_code,
    input wire logic                    sample_en,
    input wire logic                    converter_enable,
    input wire logic                    conv_done_irq
);
    timeunit 1ns;
    timeprecision 100ps;

    logic        rd_take, wr_take, pm_off;
    logic        wr_ph_r, wr_done_r, ien_r;
    logic [15:0] wr_idx_r;
    logic [7:0]  wd_r;

    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    assign wr_take = hsel && htrans[1] && hready && hwrite;
    assign pm_off  = !(power_mode inside {PWR_ACTIVE, PWR_SLEEP});

    function automatic logic [7:0] chan_dec(input logic [3:0] c);
        case (c[3:2])
            2'b01:   return 8'h01 << c[1:0];
            2'b10:   return 8'h10 << c[1:0];
            default: return 8'h00;
        endcase
    endfunction : chan_dec

    // Shadow of the last write, held until the next write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ph_r   <= 1'b0;
            wr_done_r <= 1'b0;
            ien_r     <= 1'b0;
            wr_idx_r  <= 16'h0000;
            wd_r      <= 8'h00;
        end
        else
        begin
            wr_ph_r   <= wr_take;
            wr_done_r <= wr_ph_r;
            if (wr_take)
                wr_idx_r <= haddr[17:2];
            if (wr_ph_r)
                wd_r <= hwdata[7:0];
            if (wr_ph_r && wr_idx_r == IDX_IRQ_EN2)
                ien_r <= hwdata[IRQ_DONE_BIT];
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_mode_ones;
        rd_take && haddr[17:2] == IDX_MODE |->
            ##1 !hreadyout ##1 hreadyout && hrdata[5:4] == 2'b11;
    endproperty
    a_mode_ones: assert property (p_mode_ones)
        else $error("mode bits 5:4 not one");

    property p_start_ones;
        rd_take && haddr[17:2] == IDX_START |->
            ##1 !hreadyout ##1 hreadyout && hrdata[6:0] == 7'h7f;
    endproperty
    a_start_ones: assert property (p_start_ones)
        else $error("start bits 6:0 not one");

    property p_onehot;
        $onehot0(ch_sel);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("more than one input selected");

    property p_chan;
        wr_done_r && wr_idx_r == IDX_MODE && converter_enable && !pm_off
            |-> ##[0:1] ch_sel == chan_dec(wd_r[3:0]);
    endproperty
    a_chan: assert property (p_chan)
        else $error("input select does not follow field");

    property p_stby;
        wr_done_r && wr_idx_r == IDX_CLK_STOP1
            |-> ##[0:1] converter_enable == wd_r[STOP1_CONV_BIT];
    endproperty
    a_stby: assert property (p_stby)
        else $error("standby output does not follow bit 4");

    // Two cycles of margin in case the mode input is registered
    property p_freeze;
        pm_off && $past(pm_off) && $past(pm_off, 2)
            |-> $stable(dac_code) && $stable(sample_en);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("converter moved while stopped");

    property p_sample_gate;
        $rose(sample_en) |-> !$past(pm_off) && $past(converter_enable);
    endproperty
    a_sample_gate: assert property (p_sample_gate)
        else $error("sampling began while not operating");

    property p_irq_gate;
        conv_done_irq |-> $past(ien_r);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised while disabled");
endmodule : adc_seq_monitor

bind adc_sequencing_control adc_seq_monitor adc_seq_monitor_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .power_mode(power_mode),
    .ch_sel(ch_sel), .dac_code(dac_code), .sample_en(sample_en),
    .converter_enable(converter_enable), .conv_done_irq(conv_done_irq)
);

// file: dv/analog_core_model.sv
module analog_core_model
(
    // Analog core side
    input wire logic            hclk,
    input wire logic [7:0]      ch_sel,
    input wire logic [9:0]      dac_code,
    input wire logic            sample_en,
    input wire logic [7:0][9:0] levels,
    output logic                comp_in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [9:0] held_r = 10'h000;

    // No input selected samples ground
    always @(posedge hclk)
    begin
        if (sample_en)
        begin
            held_r <= 10'h000;
            for (int i = 0; i < 8; i++)
                if (ch_sel[i])
                    held_r <= levels[i];
        end
    end

    assign comp_in = (held_r >= dac_code);
endmodule : analog_core_model

// file: dv/tb_adc_sequencing_control.sv
module tb_adc_sequencing_control;
    import adc_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        logic [31:0] v;
        logic [31:0] m;
    } note_t;

    logic            hclk = 1'b0;
    logic            hresetn, hsel, hwrite, trig, rd_pend;
    logic [31:0]     haddr, hwdata, hrdata, q, seed;
    logic [1:0]      htrans;
    logic [2:0]      hsize;
    logic            hreadyout, hresp, comp_in, sample_en, cen, irq;
    logic [7:0]      ch_sel;
    logic [9:0]      dac_code;
    logic [7:0][9:0] levels;
    pwr_mode_t       pm;
    note_t           exp_q[$];
    note_t           nt;
    int              err_total, total_checks, n, ch;
    realtime         t0;

    always #2.5 hclk = ~hclk;

    adc_sequencing_control adc_sequencing_control_inst (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .power_mode(pm),
        .external_trigger_pin(trig), .comp_in(comp_in), .ch_sel(ch_sel),
        .dac_code(dac_code), .sample_en(sample_en),
        .converter_enable(cen), .conv_done_irq(irq)
    );

    analog_core_model analog_core_model_inst (
        .hclk(hclk), .ch_sel(ch_sel), .dac_code(dac_code),
        .sample_en(sample_en), .levels(levels), .comp_in(comp_in)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [7:0] ch_exp(input logic [3:0] c);
        if (c[3:2] == 2'b01)
            return 8'h01 << c[1:0];
        if (c[3:2] == 2'b10)
            return 8'h10 << c[1:0];
        return 8'h00;
    endfunction : ch_exp

    task finish_test;
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task tmo(input int w, input int lim);
        if (w >= lim)
        begin
            chk("wait_bound", 32'h0, 32'h1);
            finish_test();
        end
    endtask : tmo

    task wait_rdy;
        int w;
        w = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && w < 20)
        begin
            w++;
            @(posedge hclk);
        end
        tmo(w, 20);
    endtask : wait_rdy

    task bus(input logic wr, input logic [15:0] idx, input logic [7:0] d,
             input logic [7:0] e, input logic [7:0] m);
        hsel   <= 1'b1;
        haddr  <= {14'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        if (!wr)
            exp_q.push_back('{{24'h0, e}, {24'hffffff, m}});
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wait_rdy();
        q = hrdata;
    endtask : bus

    task wr(input logic [15:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 8'h00, 8'h00);
    endtask : wr

    task rd(input logic [15:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00, e, 8'hff);
    endtask : rd

    // Counts edges until the request shows, sampled just after each edge
    task wait_irq;
        n = 0;
        do
        begin
            @(posedge hclk);
            #1;
            n++;
        end
        while (irq !== 1'b1 && n < 400);
        tmo(n, 400);
    endtask : wait_irq

    always @(posedge hclk)
    begin
        if (rd_pend && hreadyout === 1'b1)
        begin
            rd_pend = 1'b0;
            nt = exp_q.pop_front();
            chk("hrdata", nt.v & nt.m, hrdata & nt.m);
        end
        if (hsel && htrans[1] && hreadyout && !hwrite)
            rd_pend = 1'b1;
    end

    initial
    begin
        hresetn      = 1'b0;
        hsel         = 1'b0;
        haddr        = 32'h0;
        htrans       = 2'b00;
        hwrite       = 1'b0;
        hsize        = 3'b010;
        hwdata       = 32'h0;
        pm           = PWR_ACTIVE;
        trig         = 1'b0;
        rd_pend      = 1'b0;
        err_total    = 0;
        total_checks = 0;
        seed         = 32'h335f;
        for (int i = 0; i < 8; i++)
        begin
            seed      = lfsr(seed);
            levels[i] = seed[9:0];
        end
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(IDX_MODE, 8'h30);
        rd(IDX_START, 8'h7f);
        rd(IDX_CLK_STOP1, 8'hff);
        rd(16'h0100, 8'h00);
        wr(IDX_MODE, 8'h0f);
        rd(IDX_MODE, 8'h3f);
        wr(IDX_CLK_STOP1, 8'h00);
        rd(IDX_CLK_STOP1, 8'hc0);
        chk("converter_enable", 32'h0, {31'h0, cen});
        wr(IDX_START, 8'h80);
        rd(IDX_START, 8'h7f);
        wr(IDX_CLK_STOP1, 8'hff);
        repeat (10) @(posedge hclk);
        for (int c = 0; c < 16; c++)
        begin
            wr(IDX_MODE, 8'(c));
            repeat (2) @(posedge hclk);
            chk("ch_sel", {24'h0, ch_exp(4'(c))}, {24'h0, ch_sel});
        end
        wr(IDX_IRQ_EN2, 8'h08);
        // Slow, fast, then slow with the request masked
        for (int i = 0; i < 3; i++)
        begin
            seed = lfsr(seed);
            ch   = int'(seed[2:0]);
            if (i == 2)
                wr(IDX_IRQ_EN2, 8'h00);
            wr(IDX_MODE, {i == 1, 3'b011, seed[2], !seed[2], seed[1:0]});
            wr(IDX_START, 8'h80);
            if (i < 2)
            begin
                wait_irq();
                chk("conv_time", (i == 1) ? 32'd34 : 32'd65, n);
            end
            else
            begin
                repeat (70) @(posedge hclk);
                chk("irq", 32'h0, {31'h0, irq});
            end
            rd(IDX_START, 8'h7f);
            rd(IDX_RESULT_HIGH, levels[ch][9:2]);
            rd(IDX_RESULT_LOW, {levels[ch][1:0], 6'h00});
            bus(1'b0, IDX_IRQ_REQ2, 8'h00, 8'h08, 8'h08);
            wr(IDX_IRQ_REQ2, 8'h00);
            repeat (2) @(posedge hclk);
            chk("irq", 32'h0, {31'h0, irq});
        end
        wr(IDX_IRQ_EN2, 8'h08);
        wr(IDX_MODE, 8'h44);
        wr(IDX_START, 8'h80);
        repeat (20) @(posedge hclk);
        wr(IDX_START, 8'h00);
        rd(IDX_START, 8'h7f);
        repeat (70) @(posedge hclk);
        bus(1'b0, IDX_IRQ_REQ2, 8'h00, 8'h00, 8'h08);
        wr(IDX_START, 8'h80);
        repeat (30) @(posedge hclk);
        for (int m = 2; m < 6; m++)
        begin
            pm <= pwr_mode_t'(m);
            repeat (25) @(posedge hclk);
        end
        rd(IDX_START, 8'hff);
        pm <= PWR_SLEEP;
        wait_irq();
        rd(IDX_RESULT_HIGH, levels[0][9:2]);
        wr(IDX_IRQ_REQ2, 8'h00);
        wr(IDX_PORT_MODE1, 8'h10);
        wr(IDX_MODE, 8'h45);
        // Rising then falling; a second edge lands mid-conversion
        for (int e = 0; e < 2; e++)
        begin
            wr(IDX_EDGE_SEL, (e == 0) ? 8'h10 : 8'h00);
            trig <= !trig;
            t0 = $realtime;
            repeat (8) @(posedge hclk);
            rd(IDX_START, 8'hff);
            trig <= !trig;
            repeat (3) @(posedge hclk);
            trig <= !trig;
            wait_irq();
            n = int'(($realtime - t0) / 5.0);
            chk("trig_time", 32'h1, {31'h0, n inside {[66:72]}});
            rd(IDX_START, 8'h7f);
            wr(IDX_IRQ_REQ2, 8'h00);
        end
        wr(IDX_PORT_MODE1, 8'h00);
        wr(IDX_EDGE_SEL, 8'h10);
        trig <= 1'b1;
        repeat (10) @(posedge hclk);
        rd(IDX_START, 8'h7f);
        finish_test();
    end
endmodule : tb_adc_sequencing_control
